//--- shared/sct_cfg.svh
// Overview of operation
// - Two identical 16-bit counters, each behind a power-of-two prescaler.
// - Basic counters advance on prescaled clock or on each edge of chosen tick.
// - Basic counters offer one-shot and periodic modes.
// - Third counter is 16-bit, clocked by 24 MHz, 2 MHz or 32 kHz tick, free of engine state.
// - Third counter has four channels, each capture or compare, one-shot or periodic.
// - Channel matches give engine events, ADC triggers and PWM or waveform outputs.
`ifndef SCT_CFG_SVH
`define SCT_CFG_SVH
`define SCT_CNT_W      16
`define SCT_PRE_W      4
`define SCT_NCH        4
`define SCT_CNT_ZERO   16'h0000
`define SCT_CNT_ONE    16'h0001
`define SCT_PRE_ZERO   16'h0000
`define SCT_SRC_24M    2'h0
`define SCT_SRC_2M     2'h1
`define SCT_SRC_32K    2'h2
`endif

//--- shared/sct_pkg.sv
package sct_pkg;
  typedef enum logic {SCT_ONESHOT, SCT_PERIODIC} sct_mode_e;
  typedef enum logic [1:0] {SCT_IDLE, SCT_RUN, SCT_DONE} sct_state_e;
  // Basic counter configuration
  typedef struct packed {
    logic        tick_sel;   // 1: count tick edges, 0: prescaled clock
    logic [3:0]  pre_exp;    // divide by 2**pre_exp
    sct_mode_e   mode;
    logic [15:0] target;
  } sct_basic_cfg_s;
  // Channel configuration of the third counter
  typedef struct packed {
    logic        capture;    // 1: capture on input edge, 0: compare
    sct_mode_e   mode;
    logic        enable;
    logic [15:0] value;
  } sct_ch_cfg_s;
endpackage

//--- hdl/sct_basic_timer.sv
`timescale 1ns/1ps
`include "sct_cfg.svh"
module sct_basic_timer
  import sct_pkg::*;
#(
  parameter int CNT_W = `SCT_CNT_W
)
(
  input  wire logic           sys_clk,
  input  wire logic           rst,
  input  wire sct_pkg::sct_basic_cfg_s cfg,
  input  wire logic           arm,
  input  wire logic           stop,
  input  wire logic           tick_in,
  output logic [CNT_W-1:0]    count_reg,
  output logic                running_reg,
  output logic                event_reg
);
  sct_state_e       state_reg;
  sct_state_e       state_next;
  logic [15:0]      pre_reg;
  logic             tick_d_reg;
  logic [15:0]      pre_mask;
  logic             pre_hit;
  logic             tick_edge;
  logic             adv;
  logic             at_target;

  // =====================================================
  // Count source selection
  assign pre_mask  = 16'((32'h0000_0001 << cfg.pre_exp) - 32'h0000_0001);
  assign pre_hit   = (pre_reg & pre_mask) == pre_mask;
  assign tick_edge = tick_in ^ tick_d_reg;
  assign adv       = (state_reg == SCT_RUN) && (cfg.tick_sel ? tick_edge : pre_hit);
  assign at_target = count_reg == CNT_W'(cfg.target);

  // =====================================================
  // Mode control
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SCT_IDLE, SCT_DONE:
        if (arm) state_next = SCT_RUN;
      SCT_RUN:
        if (stop) state_next = SCT_IDLE;
        else if (adv && at_target && cfg.mode == SCT_ONESHOT)
          state_next = SCT_DONE;
      default:
        state_next = SCT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_reg   <= SCT_IDLE;
      pre_reg     <= `SCT_PRE_ZERO;
      tick_d_reg  <= 1'b0;
      count_reg   <= '0;
      running_reg <= 1'b0;
      event_reg   <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      tick_d_reg  <= tick_in;
      running_reg <= state_next == SCT_RUN;
      event_reg   <= adv && at_target;
      if (state_reg != SCT_RUN || pre_hit)
        pre_reg <= `SCT_PRE_ZERO;
      else
        pre_reg <= pre_reg + `SCT_CNT_ONE;
      if (arm && state_reg != SCT_RUN)
        count_reg <= '0;
      else if (adv)
        count_reg <= at_target ? '0 : count_reg + CNT_W'(1);
    end
  end

  property p_target_event;
    @(posedge sys_clk) disable iff (rst)
    (adv && at_target) |=> event_reg;
  endproperty
  a_target_event: assert property (p_target_event)
    else $error("missing target event");

  property p_oneshot_stop;
    @(posedge sys_clk) disable iff (rst)
    (adv && at_target && cfg.mode == SCT_ONESHOT && !stop) |=> !running_reg;
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop)
    else $error("one-shot kept running");

  property p_periodic_wrap;
    @(posedge sys_clk) disable iff (rst)
    (adv && at_target && cfg.mode == SCT_PERIODIC && !stop) |=> running_reg && count_reg == '0;
  endproperty
  a_periodic_wrap: assert property (p_periodic_wrap)
    else $error("periodic did not restart");

  property p_prescale;
    @(posedge sys_clk) disable iff (rst)
    (state_reg == SCT_RUN && !cfg.tick_sel && !pre_hit && !arm) |=> $stable(count_reg);
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("count moved off prescale");
  c_periodic: cover property (@(posedge sys_clk) event_reg && running_reg);
endmodule

//--- hdl/sct_timers.sv
`timescale 1ns/1ps
`include "sct_cfg.svh"
module sct_timers
  import sct_pkg::*;
#(
  parameter int CNT_W = `SCT_CNT_W,
  parameter int NCH   = `SCT_NCH
)
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire sct_pkg::sct_basic_cfg_s t0_cfg,
  input  wire logic                    t0_arm,
  input  wire logic                    t0_stop,
  input  wire logic                    t0_tick,
  input  wire sct_pkg::sct_basic_cfg_s t1_cfg,
  input  wire logic                    t1_arm,
  input  wire logic                    t1_stop,
  input  wire logic                    t1_tick,
  input  wire logic                    t2_run,
  input  wire logic [1:0]              t2_clk_sel,
  input  wire logic                    tick_24m,
  input  wire logic                    tick_2m,
  input  wire logic                    tick_32k,
  input  wire logic [15:0]             t2_period,
  input  wire sct_pkg::sct_ch_cfg_s [NCH-1:0] ch_cfg,
  input  wire logic [NCH-1:0]          ch_arm,
  input  wire logic [NCH-1:0]          ch_cap_in,
  output logic [CNT_W-1:0]             t0_count,
  output logic                         t0_running,
  output logic                         t0_event,
  output logic [CNT_W-1:0]             t1_count,
  output logic                         t1_running,
  output logic                         t1_event,
  output logic [15:0]                  t2_count_reg,
  output logic [NCH-1:0][15:0]         ch_capture_reg,
  output logic [NCH-1:0]               ch_event_reg,
  output logic [NCH-1:0]               adc_trig_reg,
  output logic [NCH-1:0]               pwm_out_reg
);
  logic             t2_tick;
  logic             t2_wrap;
  logic [NCH-1:0]   ch_live_reg;
  logic [NCH-1:0]   cap_d_reg;
  logic [NCH-1:0]   ch_hit;
  logic [NCH-1:0]   cap_edge;

  // =====================================================
  // Basic counters; either engine or CPU drives cfg/arm via a shared port
  sct_basic_timer #(.CNT_W(CNT_W)) u_t0 (
    .sys_clk(sys_clk), .rst(rst), .cfg(t0_cfg), .arm(t0_arm), .stop(t0_stop),
    .tick_in(t0_tick), .count_reg(t0_count), .running_reg(t0_running),
    .event_reg(t0_event));
  sct_basic_timer #(.CNT_W(CNT_W)) u_t1 (
    .sys_clk(sys_clk), .rst(rst), .cfg(t1_cfg), .arm(t1_arm), .stop(t1_stop),
    .tick_in(t1_tick), .count_reg(t1_count), .running_reg(t1_running),
    .event_reg(t1_event));

  // =====================================================
  // Third counter; the three rates arrive as enables since the block has one clock
  assign t2_tick = t2_run && ((t2_clk_sel == `SCT_SRC_24M) ? tick_24m :
                              (t2_clk_sel == `SCT_SRC_2M)  ? tick_2m  :
                              (t2_clk_sel == `SCT_SRC_32K) ? tick_32k : 1'b0);
  assign t2_wrap = t2_tick && t2_count_reg == t2_period;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      t2_count_reg <= `SCT_CNT_ZERO;
    else if (t2_tick)
      t2_count_reg <= t2_wrap ? `SCT_CNT_ZERO : t2_count_reg + `SCT_CNT_ONE;
  end

  // =====================================================
  // Channels
  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      assign ch_hit[i]   = ch_live_reg[i] && !ch_cfg[i].capture && t2_tick
                           && t2_count_reg == ch_cfg[i].value;
      assign cap_edge[i] = ch_live_reg[i] && ch_cfg[i].capture
                           && ch_cap_in[i] && !cap_d_reg[i];
      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          ch_live_reg[i]    <= 1'b0;
          cap_d_reg[i]      <= 1'b0;
          ch_capture_reg[i] <= `SCT_CNT_ZERO;
          ch_event_reg[i]   <= 1'b0;
          adc_trig_reg[i]   <= 1'b0;
          pwm_out_reg[i]    <= 1'b0;
        end
        else
        begin
          cap_d_reg[i]    <= ch_cap_in[i];
          ch_event_reg[i] <= ch_hit[i] || cap_edge[i];
          adc_trig_reg[i] <= ch_hit[i];
          if (ch_arm[i])
            ch_live_reg[i] <= ch_cfg[i].enable;
          else if ((ch_hit[i] || cap_edge[i]) && ch_cfg[i].mode == SCT_ONESHOT)
            ch_live_reg[i] <= 1'b0;
          if (cap_edge[i])
            ch_capture_reg[i] <= t2_count_reg;
          // PWM: high from period wrap, low at compare match
          if (!ch_cfg[i].enable || ch_cfg[i].capture)
            pwm_out_reg[i] <= 1'b0;
          else if (ch_hit[i])
            pwm_out_reg[i] <= 1'b0;
          else if (t2_wrap)
            pwm_out_reg[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // =====================================================
  // Checks
  property p_t2_count;
    @(posedge sys_clk) disable iff (rst)
    (t2_tick && !t2_wrap) |=> t2_count_reg == $past(t2_count_reg) + `SCT_CNT_ONE;
  endproperty
  a_t2_count: assert property (p_t2_count)
    else $error("third counter failed to advance");

  property p_t2_hold;
    @(posedge sys_clk) disable iff (rst)
    !t2_tick |=> $stable(t2_count_reg);
  endproperty
  a_t2_hold: assert property (p_t2_hold)
    else $error("third counter moved without tick");

  property p_ch_event;
    @(posedge sys_clk) disable iff (rst)
    (ch_hit[0]) |=> ch_event_reg[0] && adc_trig_reg[0] && !pwm_out_reg[0];
  endproperty
  a_ch_event: assert property (p_ch_event)
    else $error("channel 0 match not signalled");

  property p_ch_oneshot;
    @(posedge sys_clk) disable iff (rst)
    (ch_hit[0] && !ch_arm[0] && ch_cfg[0].mode == SCT_ONESHOT) |=> !ch_live_reg[0];
  endproperty
  a_ch_oneshot: assert property (p_ch_oneshot)
    else $error("one-shot channel stayed live");

  property p_capture;
    @(posedge sys_clk) disable iff (rst)
    cap_edge[1] |=> ch_capture_reg[1] == $past(t2_count_reg);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture value wrong");

  c_wrap: cover property (@(posedge sys_clk) t2_wrap);
  c_cap: cover property (@(posedge sys_clk) cap_edge[0]);
  c_pwm: cover property (@(posedge sys_clk) $rose(pwm_out_reg[0]));
endmodule

//--- tb/sct_tick_src.sv
`timescale 1ns/1ps
// ==========================================
// Rate strobes seen by the third counter
module sct_tick_src #(
  parameter int DIV_A = 2,
  parameter int DIV_B = 3,
  parameter int DIV_C = 5
)
(
  input  wire logic sys_clk,
  input  wire logic rst,
  output logic      tick_24m,
  output logic      tick_2m,
  output logic      tick_32k
);
  int cnt_reg;
  always_ff @(posedge sys_clk)
  begin
    cnt_reg <= rst ? 0 : cnt_reg + 1;
  end
  // Rates scaled down so that whole periods fit in a short run
  assign tick_24m = !rst && (cnt_reg % DIV_A == 0);
  assign tick_2m  = !rst && (cnt_reg % DIV_B == 0);
  assign tick_32k = !rst && (cnt_reg % DIV_C == 0);
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import sct_pkg::*;
  logic sys_clk = 0, rst = 1, arm = 0, stop = 0, tick = 0, t2_run = 0;
  logic [1:0] t2_clk_sel = 2'h3;
  logic [15:0] t2_period = 16'h0007, t0_count, t1_count, t2_count_reg;
  logic [3:0] ch_arm = 4'h0, ch_cap_in = 4'h0, ch_event_reg, adc_trig_reg, pwm_out_reg;
  logic tick_24m, tick_2m, tick_32k, t0_running, t1_running, t0_event, t1_event;
  logic [3:0][15:0] ch_capture_reg;
  sct_basic_cfg_s cfg = '0;
  sct_ch_cfg_s [3:0] ch_cfg = '0;
  wire [5:0] ev = {ch_event_reg, t1_event, t0_event};
  int err_total = 0, samples_checked = 0, tc = 0, g, n, exp_v;
  int divs [3] = '{2, 3, 5};
  sct_basic_cfg_s rows [4] = '{'{1'b0, 4'h0, SCT_PERIODIC, 16'h0003},
    '{1'b0, 4'h2, SCT_PERIODIC, 16'h0005}, '{1'b0, 4'h1, SCT_PERIODIC, 16'h0000},
    '{1'b1, 4'h0, SCT_PERIODIC, 16'h0004}};
  sct_tick_src ts_u (.sys_clk(sys_clk), .rst(rst), .tick_24m(tick_24m), .tick_2m(tick_2m),
    .tick_32k(tick_32k));
  // One control port set serves whichever master owns the timers
  sct_timers dut_u (
    .sys_clk(sys_clk), .rst(rst), .t0_cfg(cfg), .t0_arm(arm), .t0_stop(stop), .t0_tick(tick),
    .t1_cfg(cfg), .t1_arm(arm), .t1_stop(stop), .t1_tick(tick), .t2_run(t2_run),
    .t2_clk_sel(t2_clk_sel), .tick_24m(tick_24m), .tick_2m(tick_2m), .tick_32k(tick_32k),
    .t2_period(t2_period), .ch_cfg(ch_cfg), .ch_arm(ch_arm), .ch_cap_in(ch_cap_in),
    .t0_count(t0_count), .t0_running(t0_running), .t0_event(t0_event), .t1_count(t1_count),
    .t1_running(t1_running), .t1_event(t1_event), .t2_count_reg(t2_count_reg),
    .ch_capture_reg(ch_capture_reg), .ch_event_reg(ch_event_reg),
    .adc_trig_reg(adc_trig_reg), .pwm_out_reg(pwm_out_reg));
  // ==========================================
  // Clock and tick source, an edge every third cycle
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    tc <= (tc == 2) ? 0 : tc + 1;
    tick <= (tc == 2) ? ~tick : tick;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  // Cycles from one event to the next; bounded so a dead output cannot hang
  task automatic gap(input int b, output int gg);
    int k;
    k = 0;
    gg = 0;
    // Wait first for one event of the new setup, so the gap is timed from that event to the next
    do
    begin
      @(negedge sys_clk);
      k++;
    end while (ev[b] !== 1'b1 && k < 3000);
    do
    begin
      @(negedge sys_clk);
      gg++;
    end while (ev[b] !== 1'b1 && gg < 3000);
  endtask
  task automatic arm_t(input sct_basic_cfg_s c);
    @(posedge sys_clk);
    cfg <= c;
    stop <= 1'b1;
    @(posedge sys_clk);
    stop <= 1'b0;
    arm <= 1'b1;
    @(posedge sys_clk);
    arm <= 1'b0;
  endtask
  task automatic count_ev(input int b, input int cyc);
    n = 0;
    repeat (cyc)
    begin
      @(negedge sys_clk);
      n += ev[b];
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk("reset", {t0_count, t1_count, t2_count_reg, ev, pwm_out_reg}, 64'h0);
    foreach (rows[i])
    begin
      arm_t(rows[i]);
      exp_v = (rows[i].target + 1) * (rows[i].tick_sel ? 3 : (1 << rows[i].pre_exp));
      gap(0, g);
      chk("t0 period", g, exp_v);
      gap(1, g);
      chk("t1 period", g, exp_v);
    end
    arm_t('{1'b0, 4'h1, SCT_ONESHOT, 16'h0004});
    count_ev(0, 60);
    chk("oneshot events", n, 1);
    chk("oneshot idle", {t0_running, t1_running, t0_count, t1_count}, 0);
    arm_t('{1'b0, 4'h1, SCT_ONESHOT, 16'h0004});
    @(negedge sys_clk);
    chk("rearm", t0_running, 1);
    @(posedge sys_clk);
    ch_cfg[0] <= '{1'b0, SCT_PERIODIC, 1'b1, 16'h0002};
    ch_cfg[1] <= '{1'b1, SCT_PERIODIC, 1'b1, 16'h0000};
    ch_cfg[2] <= '{1'b0, SCT_ONESHOT, 1'b1, 16'h0005};
    ch_arm <= 4'h7;
    t2_run <= 1'b1;
    @(posedge sys_clk);
    ch_arm <= 4'h0;
    for (int s = 0; s < 3; s++)
    begin
      @(posedge sys_clk);
      t2_clk_sel <= 2'(s);
      gap(2, g);
      chk("channel period", g, 8 * divs[s]);
      chk("adc and pwm", {adc_trig_reg[0], pwm_out_reg[0]}, 2'b10);
    end
    @(posedge sys_clk);
    ch_arm <= 4'h4;
    @(posedge sys_clk);
    ch_arm <= 4'h0;
    count_ev(4, 100);
    chk("oneshot channel", n, 1);
    @(posedge sys_clk);
    ch_cap_in <= 4'h2;
    n = 0;
    @(negedge sys_clk);
    // Counter value standing at the edge that sees the rising capture input
    exp_v = t2_count_reg;
    n += {adc_trig_reg[1], 3'b0, ev[3]};
    repeat (3)
    begin
      @(negedge sys_clk);
      n += {adc_trig_reg[1], 3'b0, ev[3]};
    end
    chk("capture event", n, 1);
    chk("capture value", ch_capture_reg[1], exp_v);
    end_sim();
  end
  initial
  begin
    #(40 * 40000);
    err_total++;
    end_sim();
  end
endmodule
